// [inc/vpc_pkg.sv]
// Shared constants and types of the voice phrase command input block
package vpc_pkg;
    // ----------------------------------------
    // Code fields
    // ----------------------------------------
    localparam int CODE_W = 7;
    localparam logic [6:0] STOP_CODE = 7'h00;
    localparam logic [2:0] OPT_GROUP = 3'h0;
    localparam int OPT_DAC_BIT = 3;
    localparam int OPT_STBY_BIT = 2;
    localparam int OPT_AMP_BIT = 0;
    localparam int SER_BITS = 8;
    localparam logic [3:0] SER_CNT_W = 4'h8;
    localparam int SDAT_BIT = 0;
    localparam int SCLK_BIT = 1;
    // ----------------------------------------
    // Voice ROM layout
    // ----------------------------------------
    localparam logic [19:0] VOICE_BASE = 20'h00B00;
    localparam logic [19:0] ROM_TOP_DEF = 20'h1FFFF;
    localparam logic [19:0] ROM_TAIL = 20'h00003;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_KHZ = 50000;
    localparam int RAMP_MS = 64;
    localparam int RAMP_MIN_MS = 60;
    localparam int RAMP_MAX_MS = 68;
    localparam int RAMP_CYC = RAMP_MS * CLK_KHZ;
    localparam int STBY_MS = 200;
    localparam int STBY_CYC = STBY_MS * CLK_KHZ;
    localparam int LVL_W = 12;
    localparam logic [11:0] LVL_MAX = 12'hFFF;
    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef struct packed {
        logic is_cmd;
        logic chan;
        logic [6:0] code;
    } vpc_word_t;
    typedef struct packed {
        logic analog_voice_out_dac;
        logic stby_off;
        logic amp_half;
    } vpc_opt_t;
    localparam vpc_opt_t OPT_RST = 3'h0;
    typedef enum logic [1:0] {
        SB_RUN = 2'b00,
        SB_WAIT = 2'b01,
        SB_STBY = 2'b11
    } vpc_sb_t;
endpackage : vpc_pkg

// [rtl/vpc_shift.sv]
// Serial code entry: identifier bit plus seven code bits
`timescale 1ns/100ps
module vpc_shift (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Synchronised pin levels
    input wire logic en,
    input wire logic sck,
    input wire logic sdat,
    input wire logic chan,
    input wire logic stb_rise,
    // Assembled word
    output vpc_pkg::vpc_word_t word,
    output logic word_valid
);
    logic sck_q;
    logic [7:0] sh_q;
    logic [3:0] cnt_q;

    // ----------------------------------------
    // Shift on rising serial clock, close on strobe
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (!rstn) begin
            sck_q <= 1'b0;
            sh_q <= 8'h00;
            cnt_q <= 4'h0;
            word_valid <= 1'b0;
            word <= '0;
        end else begin
            sck_q <= sck;
            word_valid <= 1'b0;
            if (!en) begin
                cnt_q <= 4'h0;
            end else if (stb_rise) begin
                // A short or long burst is dropped rather than misread
                if (cnt_q == vpc_pkg::SER_CNT_W) begin
                    word_valid <= 1'b1;
                    word.is_cmd <= sh_q[7];
                    word.chan <= chan;
                    word.code <= sh_q[6:0];
                end
                cnt_q <= 4'h0;
            end else if (sck && !sck_q) begin
                sh_q <= {sh_q[6:0], sdat};
                if (cnt_q != 4'hF) begin
                    cnt_q <= cnt_q + 4'h1;
                end
            end
        end
    end
endmodule : vpc_shift

// [rtl/vpc_top.sv]
// Command and phrase code input of a voice synthesizer
// Behaviour
// - code zero means stop; any nonzero code picks one of 127 phrases.
// - many commands may precede an address; only the last applies, both channels.
// - host select high enables entry; serial select high serial, low parallel.
// - voice data starts at 00B00; last three ROM bytes are excluded.
// - output ramps between idle and full level over 60 to 68 ms.
// - first serial bit high marks command data, low marks address data.
// - with auto standby on, enter standby 200 ms after voice ends.
`timescale 1ns/100ps
module vpc_top #(
    parameter int RAMP_CYC = vpc_pkg::RAMP_CYC,
    parameter int STBY_CYC = vpc_pkg::STBY_CYC,
    parameter logic [19:0] ROM_TOP = vpc_pkg::ROM_TOP_DEF
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Host pins
    input wire logic play_strobe_n,
    input wire logic cmd_sel_n,
    input wire logic channel_pick,
    input wire logic [6:0] code_bus,
    input wire logic host_if_sel,
    input wire logic serial_sel,
    // Player side
    input wire logic voice_end,
    input wire logic ramp_up_req,
    input wire logic ramp_dn_req,
    input wire logic [19:0] fetch_addr,
    // Decoded phrase
    output logic phrase_valid_q,
    output logic [6:0] phrase_code_q,
    output logic phrase_chan_q,
    output logic phrase_stop_q,
    // Commands and options
    output logic cmd_apply_q,
    output logic [6:0] cmd_code_q,
    output vpc_pkg::vpc_opt_t opt_q,
    // Power and output
    output logic standby_q,
    output logic [11:0] analog_voice_out,
    output logic ramp_busy_q,
    output logic fetch_ok_q
);
    localparam int STEP_CYC = RAMP_CYC / 4096;
    localparam int RAMP_LO = RAMP_CYC / vpc_pkg::RAMP_MS * vpc_pkg::RAMP_MIN_MS;
    localparam int RAMP_HI = RAMP_CYC / vpc_pkg::RAMP_MS * vpc_pkg::RAMP_MAX_MS;

    logic [13:0] s1_q;
    logic [13:0] s2_q;
    logic stb_q;
    logic stb_rise;
    logic par_take;
    vpc_pkg::vpc_word_t par_word;
    vpc_pkg::vpc_word_t ser_word;
    logic ser_valid;
    vpc_pkg::vpc_word_t word;
    logic take;
    logic [6:0] cmd_pend_q;
    logic cmd_pend_v_q;
    vpc_pkg::vpc_sb_t sb_q;
    logic [31:0] sb_cnt_q;
    logic [31:0] step_cnt_q;
    logic ramp_dir_q;
    logic [31:0] ramp_len_h;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (!rstn) begin
            s1_q <= 14'h3E00;
            s2_q <= 14'h3E00;
            stb_q <= 1'b1;
        end else begin
            s1_q <= {play_strobe_n, cmd_sel_n, channel_pick, host_if_sel, serial_sel, 2'b00, code_bus};
            s2_q <= s1_q;
            stb_q <= s2_q[13];
        end
    end

    // Strobe release marks the end of a code; data is stable by setup time
    assign stb_rise = s2_q[13] && !stb_q;
    assign par_take = s2_q[10] && !s2_q[9] && stb_rise;
    assign par_word.is_cmd = !s2_q[12];
    assign par_word.chan = s2_q[11];
    assign par_word.code = s2_q[6:0];

    // ----------------------------------------
    // Serial entry
    // ----------------------------------------
    vpc_shift u_shift (
        .clk(clk),
        .rstn(rstn),
        .en(s2_q[10] && s2_q[9]),
        .sck(s2_q[vpc_pkg::SCLK_BIT]),
        .sdat(s2_q[vpc_pkg::SDAT_BIT]),
        .chan(s2_q[11]),
        .stb_rise(stb_rise),
        .word(ser_word),
        .word_valid(ser_valid)
    );

    // A serial word closed just as entry is switched off is dropped, not decoded late
    assign take = par_take || (ser_valid && s2_q[10] && s2_q[9]);
    assign word = ser_valid ? ser_word : par_word;

    // ----------------------------------------
    // Command latch and phrase decode
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (!rstn) begin
            cmd_pend_q <= 7'h00;
            cmd_pend_v_q <= 1'b0;
            cmd_code_q <= 7'h00;
            cmd_apply_q <= 1'b0;
            phrase_valid_q <= 1'b0;
            phrase_code_q <= 7'h00;
            phrase_chan_q <= 1'b0;
            phrase_stop_q <= 1'b0;
            opt_q <= vpc_pkg::OPT_RST;
        end else begin
            phrase_valid_q <= 1'b0;
            cmd_apply_q <= 1'b0;
            if (take && word.is_cmd) begin
                if (word.code[6:4] == vpc_pkg::OPT_GROUP) begin
                    opt_q.analog_voice_out_dac <= word.code[vpc_pkg::OPT_DAC_BIT];
                    opt_q.stby_off <= word.code[vpc_pkg::OPT_STBY_BIT];
                    opt_q.amp_half <= word.code[vpc_pkg::OPT_AMP_BIT];
                end else begin
                    // Later commands overwrite earlier ones
                    cmd_pend_q <= word.code;
                    cmd_pend_v_q <= 1'b1;
                end
            end else if (take) begin
                phrase_valid_q <= 1'b1;
                phrase_code_q <= word.code;
                phrase_chan_q <= word.chan;
                phrase_stop_q <= (word.code == vpc_pkg::STOP_CODE);
                cmd_apply_q <= cmd_pend_v_q;
                if (cmd_pend_v_q) begin
                    cmd_code_q <= cmd_pend_q;
                end
                cmd_pend_v_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Automatic standby after voice ends
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (!rstn) begin
            sb_q <= vpc_pkg::SB_RUN;
            sb_cnt_q <= 32'h0;
            standby_q <= 1'b0;
        end else begin
            unique case (sb_q)
                vpc_pkg::SB_RUN: begin
                    sb_cnt_q <= 32'h0;
                    if (voice_end && !opt_q.stby_off) begin
                        sb_q <= vpc_pkg::SB_WAIT;
                    end
                end
                vpc_pkg::SB_WAIT: begin
                    sb_cnt_q <= sb_cnt_q + 32'h1;
                    if (phrase_valid_q) begin
                        sb_q <= vpc_pkg::SB_RUN;
                    end else if (sb_cnt_q == 32'(STBY_CYC - 1)) begin
                        sb_q <= vpc_pkg::SB_STBY;
                    end
                end
                vpc_pkg::SB_STBY: begin
                    // A new phrase wakes the device
                    if (phrase_valid_q) begin
                        sb_q <= vpc_pkg::SB_RUN;
                    end
                end
            endcase
            standby_q <= (sb_q == vpc_pkg::SB_WAIT && sb_cnt_q == 32'(STBY_CYC - 1) && !phrase_valid_q)
                || (sb_q == vpc_pkg::SB_STBY && !phrase_valid_q);
        end
    end

    // ----------------------------------------
    // Output level ramp
    // ----------------------------------------
    // Full swing is 4095 steps, so the ramp cannot be shorter than 4095 cycles
    always_ff @(posedge clk) begin
        if (!rstn) begin
            step_cnt_q <= 32'h0;
            ramp_dir_q <= 1'b0;
            ramp_busy_q <= 1'b0;
            analog_voice_out <= 12'h000;
        end else if (!ramp_busy_q) begin
            step_cnt_q <= 32'h0;
            if (ramp_up_req && analog_voice_out != vpc_pkg::LVL_MAX) begin
                ramp_dir_q <= 1'b1;
                ramp_busy_q <= 1'b1;
            end else if (ramp_dn_req && analog_voice_out != 12'h000) begin
                ramp_dir_q <= 1'b0;
                ramp_busy_q <= 1'b1;
            end
        end else if (step_cnt_q == 32'(STEP_CYC - 1)) begin
            step_cnt_q <= 32'h0;
            analog_voice_out <= ramp_dir_q ? analog_voice_out + 12'h001 : analog_voice_out - 12'h001;
            if ((ramp_dir_q && analog_voice_out == vpc_pkg::LVL_MAX - 12'h001)
                || (!ramp_dir_q && analog_voice_out == 12'h001)) begin
                ramp_busy_q <= 1'b0;
            end
        end else begin
            step_cnt_q <= step_cnt_q + 32'h1;
        end
    end

    // ----------------------------------------
    // Voice area check
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (!rstn) begin
            fetch_ok_q <= 1'b0;
        end else begin
            fetch_ok_q <= fetch_addr >= vpc_pkg::VOICE_BASE && fetch_addr <= ROM_TOP - vpc_pkg::ROM_TAIL;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    // Helper: length of the running ramp
    always_ff @(posedge clk) begin
        if (!rstn || !ramp_busy_q) begin
            ramp_len_h <= 32'h0;
        end else begin
            ramp_len_h <= ramp_len_h + 32'h1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    property p_stop;
        phrase_valid_q |-> phrase_stop_q == (phrase_code_q == vpc_pkg::STOP_CODE);
    endproperty
    a_stop: assert property (p_stop) else $error("stop flag wrong");

    property p_last_cmd;
        take && !word.is_cmd && cmd_pend_v_q |=> cmd_apply_q && cmd_code_q == $past(cmd_pend_q);
    endproperty
    a_last_cmd: assert property (p_last_cmd) else $error("last command not applied");

    property p_host_off;
        !s2_q[10] |=> !phrase_valid_q && !cmd_apply_q;
    endproperty
    a_host_off: assert property (p_host_off) else $error("entry while host select low");

    property p_area;
        ##1 fetch_ok_q == ($past(fetch_addr) >= vpc_pkg::VOICE_BASE
            && $past(fetch_addr) <= ROM_TOP - vpc_pkg::ROM_TAIL);
    endproperty
    a_area: assert property (p_area) else $error("voice area check wrong");

    property p_ramp;
        $fell(ramp_busy_q) |-> $past(ramp_len_h) + 1 >= RAMP_LO && $past(ramp_len_h) + 1 <= RAMP_HI;
    endproperty
    a_ramp: assert property (p_ramp) else $error("ramp length out of window");

    property p_ser_id;
        ser_valid && s2_q[10] && s2_q[9]
            |=> (ser_word.is_cmd ? !phrase_valid_q : phrase_valid_q && phrase_code_q == $past(ser_word.code));
    endproperty
    a_ser_id: assert property (p_ser_id) else $error("serial identifier misread");

    property p_standby;
        sb_q == vpc_pkg::SB_WAIT && !phrase_valid_q && sb_cnt_q == 32'(STBY_CYC - 1) |=> standby_q
            ##1 (standby_q || $past(phrase_valid_q));
    endproperty
    a_standby: assert property (p_standby) else $error("standby not entered");

    property p_par;
        par_take && !par_word.is_cmd |=> phrase_valid_q && phrase_code_q == $past(s2_q[6:0])
            && phrase_chan_q == $past(s2_q[11]);
    endproperty
    a_par: assert property (p_par) else $error("parallel capture wrong");
endmodule : vpc_top

// [sim/vpc_host.sv]
// Host controller model that drives command and phrase codes into the block
`timescale 1ns/100ps
module vpc_host (
    // Clock
    input wire logic clk,
    // Host pins
    output logic play_strobe_n,
    output logic cmd_sel_n,
    output logic channel_pick,
    output logic [6:0] code_bus,
    output logic host_if_sel,
    output logic serial_sel
);
    // ----------------------------------------
    // Pin idle levels and transfer tasks
    // ----------------------------------------
    // Strobe, select and channel idle at their pull-up level
    initial begin
        play_strobe_n = 1'b1;
        cmd_sel_n = 1'b1;
        channel_pick = 1'b1;
        code_bus = 7'h00;
        host_if_sel = 1'b1;
        serial_sel = 1'b0;
    end

    task automatic wait_n(input int n);
        repeat (n) @(posedge clk);
    endtask : wait_n

    // Mode pins pass a synchroniser, so give them time to settle
    task automatic set_mode(input logic host, input logic ser);
        @(posedge clk);
        host_if_sel <= host;
        serial_sel <= ser;
        wait_n(4);
    endtask : set_mode

    // Command data goes out before the address it modifies
    task automatic par_word(input logic is_cmd, input logic chan, input logic [6:0] code);
        @(posedge clk);
        code_bus <= code;
        cmd_sel_n <= ~is_cmd;
        channel_pick <= chan;
        wait_n(4);
        play_strobe_n <= 1'b0;
        wait_n(20);
        play_strobe_n <= 1'b1;
        wait_n(8);
        // A released bus must not keep looking like the last code
        code_bus <= ~code;
        cmd_sel_n <= 1'b1;
        channel_pick <= 1'b1;
        wait_n(4);
    endtask : par_word

    // Identifier bit first, then code bit 6 down to bit 0
    task automatic ser_word(input logic is_cmd, input logic chan, input logic [6:0] code);
        logic [7:0] bits;
        bits = {is_cmd, code};
        @(posedge clk);
        code_bus <= 7'h00;
        channel_pick <= chan;
        wait_n(3);
        for (int i = 7; i >= 0; i--) begin
            code_bus[0] <= bits[i];
            wait_n(3);
            code_bus[1] <= 1'b1;
            wait_n(3);
            code_bus[1] <= 1'b0;
            wait_n(3);
        end
        play_strobe_n <= 1'b0;
        wait_n(4);
        play_strobe_n <= 1'b1;
        wait_n(6);
        // Pull-downs take the serial pins low between frames
        code_bus <= 7'h00;
        channel_pick <= 1'b1;
        wait_n(4);
    endtask : ser_word
endmodule : vpc_host

// [sim/vpc_top_bench.sv]
// Self-checking bench of the voice phrase command input block
`timescale 1ns/100ps
module vpc_top_bench;
    // ----------------------------------------
    // Signals, design and host model
    // ----------------------------------------
    localparam int RAMP_SIM = 8192;
    localparam int STBY_SIM = 50;
    localparam int LIMIT = 30000;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic voice_end = 1'b0;
    logic ramp_up_req = 1'b0;
    logic ramp_dn_req = 1'b0;
    logic [19:0] fetch_addr = 20'h00000;
    logic play_strobe_n, cmd_sel_n, channel_pick, host_if_sel, serial_sel;
    logic [6:0] code_bus;
    logic phrase_valid_q, phrase_chan_q, phrase_stop_q, cmd_apply_q;
    logic standby_q, ramp_busy_q, fetch_ok_q;
    logic [6:0] phrase_code_q;
    logic [6:0] cmd_code_q;
    vpc_pkg::vpc_opt_t opt_q;
    logic [11:0] analog_voice_out;
    int errors = 0;
    int n_checks = 0;
    int cycles = 0;
    logic [6:0] cmd_q[$];
    logic [6:0] exp_cmd = 7'h00;
    logic seen;
    logic seen_apply;
    logic [19:0] fa[5] = '{20'h00AFF, 20'h00B00, 20'h1FFFC, 20'h1FFFD, 20'h1FFFF};

    always #10 clk = ~clk;

    vpc_top #(.RAMP_CYC(RAMP_SIM), .STBY_CYC(STBY_SIM)) dut_u (.clk(clk), .rstn(rstn),
        .play_strobe_n(play_strobe_n), .cmd_sel_n(cmd_sel_n), .channel_pick(channel_pick),
        .code_bus(code_bus), .host_if_sel(host_if_sel), .serial_sel(serial_sel),
        .voice_end(voice_end), .ramp_up_req(ramp_up_req), .ramp_dn_req(ramp_dn_req),
        .fetch_addr(fetch_addr), .phrase_valid_q(phrase_valid_q), .phrase_code_q(phrase_code_q),
        .phrase_chan_q(phrase_chan_q), .phrase_stop_q(phrase_stop_q), .cmd_apply_q(cmd_apply_q),
        .cmd_code_q(cmd_code_q), .opt_q(opt_q), .standby_q(standby_q),
        .analog_voice_out(analog_voice_out), .ramp_busy_q(ramp_busy_q), .fetch_ok_q(fetch_ok_q));

    vpc_host host_u (.clk(clk), .play_strobe_n(play_strobe_n), .cmd_sel_n(cmd_sel_n),
        .channel_pick(channel_pick), .code_bus(code_bus), .host_if_sel(host_if_sel),
        .serial_sel(serial_sel));

    // ----------------------------------------
    // Checking, reference model and closing
    // ----------------------------------------
    task automatic finish_test;
        $display("checks=%0d errors=%0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Hang guard: a stuck handshake still reaches the report
    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            errors++;
            finish_test();
        end
    end

    // Valid and apply are one-cycle pulses, so catch them as they pass
    task automatic send(input logic is_cmd, input logic chan, input logic [6:0] code, input logic ser);
        seen = 1'b0;
        seen_apply = 1'b0;
        fork
            if (ser) host_u.ser_word(is_cmd, chan, code);
            else host_u.par_word(is_cmd, chan, code);
            repeat (150) begin
                @(posedge clk);
                #1;
                if (phrase_valid_q === 1'b1 && !seen) begin
                    seen = 1'b1;
                    seen_apply = cmd_apply_q;
                end
            end
        join
    endtask : send

    // Commands queue up; an address takes only the latest and clears the rest
    task automatic word(input logic is_cmd, input logic chan, input logic [6:0] code, input logic ser);
        logic apply;
        send(is_cmd, chan, code, ser);
        if (is_cmd) begin
            if (code[6:4] != 3'h0) cmd_q.push_back(code);
            chk(seen, 1'b0);
            return;
        end
        apply = (cmd_q.size() > 0);
        if (apply) exp_cmd = cmd_q[$];
        cmd_q.delete();
        chk(seen, 1'b1);
        chk(phrase_code_q, code);
        chk(phrase_chan_q, chan);
        chk(phrase_stop_q, code == vpc_pkg::STOP_CODE);
        chk(seen_apply, apply);
        chk(cmd_code_q, exp_cmd);
    endtask : word

    task automatic do_reset(input int n);
        @(posedge clk);
        rstn <= 1'b0;
        repeat (n) @(posedge clk);
        rstn <= 1'b1;
        #1;
        cmd_q.delete();
        exp_cmd = 7'h00;
        chk({phrase_valid_q, phrase_stop_q, cmd_code_q, opt_q, standby_q, analog_voice_out, ramp_busy_q}, 0);
    endtask : do_reset

    // Counts cycles from the sampled voice end pulse to standby
    task automatic pulse_end(output int n);
        @(posedge clk);
        voice_end <= 1'b1;
        @(posedge clk);
        voice_end <= 1'b0;
        n = 0;
        while (standby_q !== 1'b1 && n < 2 * STBY_SIM) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask : pulse_end

    initial begin
        logic c;
        int n;
        void'($urandom(2));
        do_reset(16);
        for (int i = 0; i < 14; i++) begin
            c = ($urandom % 3 == 0);
            word(c, 1'($urandom), c ? 7'($urandom_range(16, 127)) : 7'($urandom_range(1, 127)), 1'b0);
        end
        word(1'b1, 1'b0, 7'h21, 1'b0);
        word(1'b1, 1'b1, 7'h35, 1'b0);
        word(1'b1, 1'b0, 7'h7F, 1'b0);
        word(1'b0, 1'b1, 7'h00, 1'b0);
        word(1'b0, 1'b0, 7'h7F, 1'b0);
        host_u.set_mode(1'b0, 1'b0);
        send(1'b0, 1'b0, 7'h11, 1'b0);
        chk(seen, 1'b0);
        host_u.set_mode(1'b1, 1'b1);
        word(1'b1, 1'b0, 7'h46, 1'b1);
        word(1'b0, 1'b1, 7'h2B, 1'b1);
        word(1'b0, 1'b0, 7'h00, 1'b1);
        host_u.set_mode(1'b1, 1'b0);
        foreach (fa[i]) begin
            @(posedge clk);
            fetch_addr <= fa[i];
            @(posedge clk);
            #1;
            chk(fetch_ok_q, fa[i] >= vpc_pkg::VOICE_BASE && fa[i] <= vpc_pkg::ROM_TOP_DEF - vpc_pkg::ROM_TAIL);
        end
        pulse_end(n);
        chk(n >= STBY_SIM - 1 && n <= STBY_SIM + 2, 1'b1);
        word(1'b0, 1'b0, 7'h05, 1'b0);
        chk(standby_q, 1'b0);
        word(1'b1, 1'b0, 7'h04, 1'b0);
        chk(opt_q, 3'h2);
        pulse_end(n);
        chk(standby_q, 1'b0);
        // Other two option bits, with auto standby back on
        word(1'b1, 1'b0, 7'h09, 1'b0);
        chk(opt_q, 3'h5);
        // Ramp up to full, then back down to idle
        for (int d = 0; d < 2; d++) begin
            @(posedge clk);
            ramp_up_req <= (d == 0);
            ramp_dn_req <= (d == 1);
            @(posedge clk);
            ramp_up_req <= 1'b0;
            ramp_dn_req <= 1'b0;
            #1;
            chk(ramp_busy_q, 1'b1);
            n = 0;
            while (ramp_busy_q === 1'b1 && n < 2 * RAMP_SIM) begin
                @(posedge clk);
                #1;
                n++;
            end
            chk(n >= RAMP_SIM * 60 / 64 && n <= RAMP_SIM * 68 / 64, 1'b1);
            chk(analog_voice_out, (d == 0) ? vpc_pkg::LVL_MAX : 12'h000);
        end
        do_reset(500);
        finish_test();
    end
endmodule : vpc_top_bench
